/* File: core/ddr_address_map.sv */
/*
  DDR address mapping and auto-precharge stage with its AHB-Lite register
  slave. Assumes a single clock, synchronous active-low reset, and a
  downstream command path that accepts with cmdReady.
*/
// Function
// RQ1: Enable bit 30 appends auto-precharge to every user command with last set; clear appends none.
// RQ2: With auto-precharge, every bank a multi-beat command touched is precharged.
// RQ3: Column high part is address shifted right by bits 28-24 amount.
// RQ4: Chip select comes from address shifted by bits 20-16, with its mask.
// RQ5: Bank comes from address shifted by bits 12-8, with bank mask.
// RQ6: Row comes from address shifted by bits 4-0, with row mask.
// RQ7: Unused configuration bits 31, 29, 23-21, 15-13, 7-5 read zero.
// RQ8: Each field is address shifted right, then ANDed with its mask register; the column low part is the unshifted address ANDed with colLoMask_q.
module ddr_address_map (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // User request path
  input  wire logic                 reqValid,
  input  wire ddr_map_pkg::req_s    req,
  output logic                      reqReady,
  // Mapped command path
  output logic                      cmdValid,
  output ddr_map_pkg::cmd_s         cmd,
  input  wire logic                 cmdReady
);

  logic [31:0]                     config_q, config_d;
  logic [31:0]                     rowMask_q, rowMask_d;
  logic [31:0]                     selMask_q, selMask_d;
  logic [31:0]                     colHiMask_q, colHiMask_d;
  logic [31:0]                     colLoMask_q, colLoMask_d;
  logic [15:0]                     cmdCount_q;
  logic [ddr_map_pkg::NBANKS-1:0]  bankAcc_q;
  logic                            wrPend_q;
  logic [7:0]                      wrOff_q;
  logic [31:0]                     rdata_q;
  logic                            cmdValid_q;
  ddr_map_pkg::cmd_s               cmd_q;
  logic                            addrPhase;
  logic                            reqFire;
  logic [ddr_map_pkg::NBANKS-1:0]  touched;

  // Field extraction: shift right by the programmed amount, then mask
  function automatic logic [31:0] mapField(input logic [31:0] a,
                                           input logic [4:0]  sh,
                                           input logic [31:0] m);
    mapField = (a >> sh) & m;
  endfunction

  function automatic logic [ddr_map_pkg::NBANKS-1:0] bankBit(
    input logic [ddr_map_pkg::BANK_W-1:0] b);
    bankBit = ddr_map_pkg::NBANKS'(1) << b;
  endfunction

  function automatic logic [31:0] writeMerge(input logic [31:0] cur,
                                             input logic [7:0]  off,
                                             input logic [7:0]  mine,
                                             input logic [31:0] wmask);
    writeMerge = (wrPend_q && wrOff_q == mine) ? (hwdata & wmask) : cur;
    if (off != mine) writeMerge = cur;
  endfunction

  assign addrPhase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // Data-phase writes; unmapped offsets are dropped with an OKAY answer
  always_comb begin
    // RQ7: reserved bits masked
    config_d    = writeMerge(config_q, wrOff_q, ddr_map_pkg::OFF_CONFIG0,
                             ddr_map_pkg::CONFIG0_WMASK);
    // RQ8: mask registers
    rowMask_d   = writeMerge(rowMask_q, wrOff_q, ddr_map_pkg::OFF_ROW_MASK,
                             ddr_map_pkg::ROW_WMASK);
    selMask_d   = writeMerge(selMask_q, wrOff_q, ddr_map_pkg::OFF_SEL_MASK,
                             ddr_map_pkg::SEL_WMASK);
    colHiMask_d = writeMerge(colHiMask_q, wrOff_q, ddr_map_pkg::OFF_COL_HI_MASK,
                             ddr_map_pkg::COL_WMASK);
    colLoMask_d = writeMerge(colLoMask_q, wrOff_q, ddr_map_pkg::OFF_COL_LO_MASK,
                             ddr_map_pkg::COL_WMASK);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      config_q    <= ddr_map_pkg::RESET_VALUE;
      rowMask_q   <= ddr_map_pkg::RESET_VALUE;
      selMask_q   <= ddr_map_pkg::RESET_VALUE;
      colHiMask_q <= ddr_map_pkg::RESET_VALUE;
      colLoMask_q <= ddr_map_pkg::RESET_VALUE;
    end else begin
      config_q    <= config_d;
      rowMask_q   <= rowMask_d;
      selMask_q   <= selMask_d;
      colHiMask_q <= colHiMask_d;
      colLoMask_q <= colLoMask_d;
    end
  end

  // Address phase capture
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPend_q <= 1'b0;
      wrOff_q  <= 8'h00;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      wrOff_q  <= haddr[7:0];
    end
  end

  // Read data uses next-state values so a read right after a write sees it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        ddr_map_pkg::OFF_CONFIG0:     rdata_q <= config_d;
        ddr_map_pkg::OFF_ROW_MASK:    rdata_q <= rowMask_d;
        ddr_map_pkg::OFF_SEL_MASK:    rdata_q <= selMask_d;
        ddr_map_pkg::OFF_COL_HI_MASK: rdata_q <= colHiMask_d;
        ddr_map_pkg::OFF_COL_LO_MASK: rdata_q <= colLoMask_d;
        ddr_map_pkg::OFF_STATUS: begin
          rdata_q <= ({16'h0000, cmdCount_q} << ddr_map_pkg::STAT_COUNT_LSB)
                   | (32'(bankAcc_q) << ddr_map_pkg::STAT_BANKS_LSB);
        end
        default:                      rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // One output stage; a held command stalls new requests
  assign reqReady = !cmdValid_q || cmdReady;
  assign reqFire  = reqValid && reqReady;
  assign cmdValid = cmdValid_q;
  assign cmd      = cmd_q;
  assign touched  = bankAcc_q | bankBit(ddr_map_pkg::BANK_W'(mapField(req.addr,
                      config_q[ddr_map_pkg::BANK_SH_LSB +: ddr_map_pkg::SHIFT_W],
                      selMask_q >> ddr_map_pkg::BANK_MASK_LSB)));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmdValid_q <= 1'b0;
      cmd_q      <= '0;
    end else begin
      if (reqFire) begin
        cmdValid_q <= 1'b1;
        // RQ6: row field
        cmd_q.row <= ddr_map_pkg::ROW_W'(mapField(req.addr,
                       config_q[ddr_map_pkg::ROW_SH_LSB +: ddr_map_pkg::SHIFT_W], rowMask_q));
        // RQ5: bank field
        cmd_q.bank <= ddr_map_pkg::BANK_W'(mapField(req.addr,
                       config_q[ddr_map_pkg::BANK_SH_LSB +: ddr_map_pkg::SHIFT_W],
                       selMask_q >> ddr_map_pkg::BANK_MASK_LSB));
        // RQ4: chip select field
        cmd_q.chipSelect <= ddr_map_pkg::CS_W'(mapField(req.addr,
                       config_q[ddr_map_pkg::CS_SH_LSB +: ddr_map_pkg::SHIFT_W],
                       selMask_q >> ddr_map_pkg::CS_MASK_LSB));
        // RQ3: high column part beside low part
        cmd_q.column <= ddr_map_pkg::COL_W'(mapField(req.addr,
                       config_q[ddr_map_pkg::COL_SH_LSB +: ddr_map_pkg::SHIFT_W], colHiMask_q)
                       | (req.addr & colLoMask_q));
        cmd_q.write <= req.write;
        cmd_q.last  <= req.last;
        // RQ1: precharge at command end
        cmd_q.autoPrecharge <= req.last && config_q[ddr_map_pkg::AP_EN_BIT];
        // RQ2: every bank touched
        cmd_q.prechargeBanks <= (req.last && config_q[ddr_map_pkg::AP_EN_BIT])
                                ? touched : '0;
      end else if (cmdReady) begin
        cmdValid_q <= 1'b0;
      end
    end
  end

  // Banks touched by the command in progress, and completed command count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bankAcc_q  <= '0;
      cmdCount_q <= 16'h0000;
    end else if (reqFire) begin
      bankAcc_q <= req.last ? '0 : touched;
      if (req.last) cmdCount_q <= cmdCount_q + 16'h0001;
    end
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_cfgReadAddr;
    addrPhase && !hwrite && haddr[7:0] == ddr_map_pkg::OFF_CONFIG0;
  endsequence

  sequence s_rowMaskWrite;
    addrPhase && hwrite && haddr[7:0] == ddr_map_pkg::OFF_ROW_MASK ##1 1'b1;
  endsequence

  property p_apOn;
    reqFire && req.last && config_q[ddr_map_pkg::AP_EN_BIT] |=>
      cmdValid && cmd.autoPrecharge;
  endproperty
  a_apOn: assert property (p_apOn) else $error("auto-precharge missing"); // RQ1

  property p_apOff;
    reqFire && !(req.last && config_q[ddr_map_pkg::AP_EN_BIT]) |=>
      !cmd.autoPrecharge && cmd.prechargeBanks == '0;
  endproperty
  a_apOff: assert property (p_apOff) else $error("unexpected auto-precharge"); // RQ1

  property p_allBanks;
    reqFire && req.last && config_q[ddr_map_pkg::AP_EN_BIT] |=>
      cmd.prechargeBanks == $past(touched) && (cmd.prechargeBanks & bankBit(cmd.bank)) != '0;
  endproperty
  a_allBanks: assert property (p_allBanks) else $error("touched bank not precharged"); // RQ2

  property p_column;
    reqFire |=> cmd.column == ddr_map_pkg::COL_W'($past(
      ((req.addr >> config_q[ddr_map_pkg::COL_SH_LSB +: ddr_map_pkg::SHIFT_W]) & colHiMask_q)
      | (req.addr & colLoMask_q)));
  endproperty
  a_column: assert property (p_column) else $error("column mapping wrong"); // RQ3

  property p_chipSel;
    reqFire |=> cmd.chipSelect == ddr_map_pkg::CS_W'($past(
      (req.addr >> config_q[ddr_map_pkg::CS_SH_LSB +: ddr_map_pkg::SHIFT_W])
      & (selMask_q >> ddr_map_pkg::CS_MASK_LSB)));
  endproperty
  a_chipSel: assert property (p_chipSel) else $error("chip select wrong"); // RQ4

  property p_bank;
    reqFire |=> cmd.bank == ddr_map_pkg::BANK_W'($past(
      (req.addr >> config_q[ddr_map_pkg::BANK_SH_LSB +: ddr_map_pkg::SHIFT_W])
      & (selMask_q >> ddr_map_pkg::BANK_MASK_LSB)));
  endproperty
  a_bank: assert property (p_bank) else $error("bank mapping wrong"); // RQ5

  property p_row;
    reqFire |=> cmd.row == ddr_map_pkg::ROW_W'($past(
      (req.addr >> config_q[ddr_map_pkg::ROW_SH_LSB +: ddr_map_pkg::SHIFT_W]) & rowMask_q));
  endproperty
  a_row: assert property (p_row) else $error("row mapping wrong"); // RQ6

  property p_reservedZero;
    s_cfgReadAddr |=> (hrdata & ~ddr_map_pkg::CONFIG0_WMASK) == 32'h0000_0000;
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bit read one"); // RQ7

  property p_maskWrite;
    s_rowMaskWrite |=> rowMask_q == ($past(hwdata) & ddr_map_pkg::ROW_WMASK);
  endproperty
  a_maskWrite: assert property (p_maskWrite) else $error("row mask not stored"); // RQ8

endmodule

/* File: core/ddr_map_pkg.sv */
/*
  Shared constants and carriers for the DDR address-mapping block: register
  offsets, field positions, writable masks and the request/command structs.
  Assumes a 32-bit AHB-Lite register bus and a 32-bit user address.
*/
package ddr_map_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONFIG0     = 8'h00;
  localparam logic [7:0] OFF_ROW_MASK    = 8'h04;
  localparam logic [7:0] OFF_SEL_MASK    = 8'h08;
  localparam logic [7:0] OFF_COL_HI_MASK = 8'h0C;
  localparam logic [7:0] OFF_COL_LO_MASK = 8'h10;
  localparam logic [7:0] OFF_STATUS      = 8'h14;

  // Configuration word 0 fields
  localparam int AP_EN_BIT   = 30;
  localparam int COL_SH_LSB  = 24;
  localparam int CS_SH_LSB   = 16;
  localparam int BANK_SH_LSB = 8;
  localparam int ROW_SH_LSB  = 0;
  localparam int SHIFT_W     = 5;

  // Select-mask register fields
  localparam int CS_MASK_LSB   = 8;
  localparam int BANK_MASK_LSB = 0;

  // Status register fields
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_BANKS_LSB = 16;

  // Field widths
  localparam int ROW_W  = 13;
  localparam int BANK_W = 3;
  localparam int CS_W   = 3;
  localparam int COL_W  = 27;
  localparam int NBANKS = 8;

  // Writable bits; all others read as zero
  localparam logic [31:0] CONFIG0_WMASK = 32'h5F1F_1F1F;
  localparam logic [31:0] ROW_WMASK     = 32'h0000_1FFF;
  localparam logic [31:0] SEL_WMASK     = 32'h0000_0707;
  localparam logic [31:0] COL_WMASK     = 32'h07FF_FFFF;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        last;
  } req_s;

  typedef struct packed {
    logic [ROW_W-1:0]  row;
    logic [BANK_W-1:0] bank;
    logic [CS_W-1:0]   chipSelect;
    logic [COL_W-1:0]  column;
    logic              write;
    logic              last;
    logic              autoPrecharge;
    logic [NBANKS-1:0] prechargeBanks;
  } cmd_s;

endpackage

/* File: testbench/ddr_address_map_precharge_tb.sv */
/*
  Self-checking bench for the DDR address-mapping stage.
  Assumes a zero-wait AHB-Lite slave and the command sink model.
*/
module ddr_address_map_precharge_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0]  RS = 5'h10;
  localparam logic [4:0]  BS = 5'h0D;
  localparam logic [4:0]  CS = 5'h1B;
  localparam logic [4:0]  KS = 5'h03;
  localparam logic [31:0] HI = 32'h0000_3FF8;
  localparam logic [31:0] LO = 32'h0000_0007;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, reqValid = 0, stall = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, reqReady, cmdValid, cmdReady;
  wire logic hready = hreadyout;
  ddr_map_pkg::req_s req = '0;
  ddr_map_pkg::cmd_s cmd, got, c;
  int taken, mark, n_fail = 0, checks = 0;
  ddr_address_map i_ddr_address_map (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .reqValid, .req, .reqReady,
    .cmdValid, .cmd, .cmdReady);
  ddr_cmd_sink i_ddr_cmd_sink (.clk, .nrst, .stall, .cmdValid, .cmd, .cmdReady, .got,
    .taken);
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Kind 0 bus ready, 1 request taken, 2 sink has reached mark
  task automatic waitHi(input int kind);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((kind == 0 ? hready : kind == 1 ? reqReady : taken >= mark) !== 1'b1
               && n < 50);
    if (n >= 50) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    waitHi(0);
    htrans <= 2'h0;
    hwdata <= d;
    waitHi(0);
    rd = hrdata;
  endtask
  task automatic cfgAll(input logic ap);
    logic [31:0] d;
    bus(1, ddr_map_pkg::OFF_CONFIG0, {1'b0, ap, 1'b0, KS, 3'h0, CS, 3'h0, BS, 3'h0, RS}, d);
    bus(1, ddr_map_pkg::OFF_ROW_MASK, 32'h0000_1FFF, d);
    bus(1, ddr_map_pkg::OFF_SEL_MASK, 32'h0000_0507, d);
    bus(1, ddr_map_pkg::OFF_COL_HI_MASK, HI, d);
    bus(1, ddr_map_pkg::OFF_COL_LO_MASK, LO, d);
  endtask
  task automatic issue(input logic [31:0] a, input logic last);
    mark = taken + 1;
    reqValid <= 1'b1;
    req <= '{addr: a, write: last, last: last};
    waitHi(1);
    reqValid <= 1'b0;
    waitHi(2);
    c = got;
  endtask
  task automatic chkMap(input logic [31:0] a);
    chk({19'h0, c.row}, (a >> RS) & 32'h1FFF);
    chk({29'h0, c.bank}, (a >> BS) & 32'h7);
    chk({29'h0, c.chipSelect}, (a >> CS) & 32'h5);
    chk({5'h0, c.column}, ((a >> KS) & HI) | (a & LO));
    chk({30'h0, c.write, c.last}, 32'h3);
  endtask
  task automatic tRegs;
    logic [31:0] d;
    bus(0, ddr_map_pkg::OFF_CONFIG0, 32'h0, d);
    chk(d, 32'h0000_0000);
    bus(1, ddr_map_pkg::OFF_CONFIG0, 32'hFFFF_FFFF, d);
    bus(0, ddr_map_pkg::OFF_CONFIG0, 32'h0, d);
    chk(d, 32'h5F1F_1F1F);
    bus(1, 8'h40, 32'hFFFF_FFFF, d);
    chk({31'h0, hresp}, 32'h0);
    bus(0, 8'h40, 32'h0, d);
    chk(d, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic tMap;
    logic [31:0] a[3] = '{32'hA5C3_7E19, 32'h1234_5678, 32'hFFFF_FFFF};
    cfgAll(0);
    foreach (a[i]) begin
      issue(a[i], 1'b1);
      chkMap(a[i]);
      chk({23'h0, c.autoPrecharge, c.prechargeBanks}, 32'h0);
    end
    $display("test map done");
  endtask
  task automatic tPre;
    int b[3] = '{1, 4, 6};
    logic [31:0] d;
    cfgAll(1);
    foreach (b[i]) begin
      issue(32'h00A0_0000 | (b[i] << 13), i == 2);
      chk({31'h0, c.autoPrecharge}, i == 2);
      if (i == 1) begin
        // Mid-command status: banks 1 and 4 touched, three commands done
        bus(0, ddr_map_pkg::OFF_STATUS, 32'h0, d);
        chk(d, 32'h0012_0003);
      end
    end
    chk({24'h0, c.prechargeBanks}, 32'h52);
    issue(32'h0000_4000, 1'b1);
    chk({23'h0, c.autoPrecharge, c.prechargeBanks}, 32'h104);
    $display("test precharge done");
  endtask
  task automatic tStall;
    stall <= 1'b1;
    mark = taken + 2;
    reqValid <= 1'b1;
    req <= '{addr: 32'h1357_9BDF, write: 1'b0, last: 1'b1};
    waitHi(1);
    req <= '{addr: 32'h0246_8ACE, write: 1'b1, last: 1'b1};
    repeat (4) begin
      @(posedge clk);
      chk({30'h0, cmdValid, reqReady}, 32'h2);
      chk({19'h0, cmd.row}, (32'h1357_9BDF >> RS) & 32'h1FFF);
    end
    stall <= 1'b0;
    waitHi(1);
    reqValid <= 1'b0;
    waitHi(2);
    c = got;
    chkMap(32'h0246_8ACE);
    $display("test stall done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    tRegs();
    tMap();
    tPre();
    tStall();
    report_and_stop();
  end
endmodule

/* File: testbench/ddr_cmd_sink.sv */
/*
  Stand-in for the DDR devices behind the mapping stage.
  Assumes the cmdValid/cmdReady handshake of the mapped command path.
*/
module ddr_cmd_sink (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Slow-device control
  input  wire logic              stall,
  // Command path
  input  wire logic              cmdValid,
  input  wire ddr_map_pkg::cmd_s cmd,
  output logic                   cmdReady,
  // Capture
  output ddr_map_pkg::cmd_s      got,
  output int                     taken
);
  timeunit 1ns;
  timeprecision 100ps;
  // A stalled device refuses every command
  assign cmdReady = !stall;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      taken <= 0;
    end else if (cmdValid && cmdReady) begin
      got   <= cmd;
      taken <= taken + 1;
    end
  end
endmodule
